// File: testbench/bcs_clock_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_clock_chk (
	input wire mclk,
	input wire rst_b,
	input wire por_rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire [7:0] reg_rdata,
	input wire cpu_clock_off,
	input wire sub_clock_off,
	input wire bias_gen_off,
	input wire lf_osc_off,
	input wire crystal_fault_signal,
	input wire nmi_accept,
	input wire main_clk,
	input wire peripheral_clk,
	input wire first_crystal_en,
	input wire second_crystal_en,
	input wire bias_gen_en,
	input wire [2:0] bias_res_sel,
	input wire osc_supply_range,
	input wire first_crystal_high_range,
	input wire osc_fault_flag,
	input wire nmi_req
);
	// shadows of the registers, rebuilt from the write strobes
	reg [7:0] sel_ff;
	reg [7:0] osc_ff;
	reg ie_ff;
	wire ring_need = (!cpu_clock_off && !sel_ff[7]) ||
		(!sub_clock_off && !sel_ff[3]);
	always @(posedge mclk) begin
		if (reg_wr && reg_addr == 8'h58) sel_ff <= reg_wdata;
		if (reg_wr && reg_addr == 8'h57) osc_ff <= reg_wdata;
		if (reg_wr && reg_addr == 8'h00) ie_ff <= reg_wdata[1];
		// accept beats a same-cycle write
		if (nmi_accept) ie_ff <= 1'b0;
		if (!rst_b) sel_ff <= 8'h00;
		if (!rst_b) osc_ff[3:0] <= 4'h4;
		if (!rst_b) ie_ff <= 1'b0;
		if (!por_rst_b) osc_ff[7:4] <= 4'h0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence main_parked;
		cpu_clock_off [*2] ##0 !main_clk;
	endsequence
	sequence sub_parked;
		sub_clock_off [*2] ##0 !peripheral_clk;
	endsequence
	chk_reset_state: assert property ($rose(rst_b) |-> reg_rdata == 8'h00
		&& !main_clk && bias_res_sel == 3'h4) else $error("reset state");
	chk_main_gate: assert property (main_parked |=> !main_clk)
		else $error("main clock ran");
	chk_sub_gate: assert property (sub_parked |=> !peripheral_clk)
		else $error("peripheral clock ran");
	chk_lf_stop: assert property (first_crystal_en ==
		(!lf_osc_off || sel_ff[7:6] == 2'h3)) else $error("lf enable");
	chk_xt2_stop: assert property (second_crystal_en ==
		(!osc_ff[7] || sel_ff[7:6] == 2'h2 || sel_ff[3]))
		else $error("xt2 enable");
	chk_bias_gen: assert property (bias_gen_en ==
		(!bias_gen_off || ring_need)) else $error("bias enable");
	chk_osc_fields: assert property (bias_res_sel == osc_ff[2:0]
		&& osc_supply_range == osc_ff[3] &&
		first_crystal_high_range == osc_ff[6]) else $error("osc fields");
	chk_fault_sync: assert property (
		osc_fault_flag == $past(crystal_fault_signal, 2))
		else $error("fault flag");
	chk_nmi_request: assert property (nmi_req == (osc_fault_flag && ie_ff))
		else $error("nmi request");
	chk_nmi_clear: assert property (nmi_accept |=> !nmi_req)
		else $error("nmi not cleared");
endmodule // bcs_clock_chk
bind bcs_clock_ctrl bcs_clock_chk bcs_clock_chk_i (.*);
`default_nettype wire

// File: testbench/bcs_clock_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bcs_clock_ctrl_bench;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic por_rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cpu_clock_off = 1'b0;
	logic sub_clock_off = 1'b0;
	logic bias_gen_off = 1'b0;
	logic lf_osc_off = 1'b0;
	logic crystal_fault_signal = 1'b0;
	logic nmi_accept = 1'b0;
	wire [7:0] reg_rdata;
	wire [2:0] bias_res_sel;
	wire main_clk, peripheral_clk, aux_clk, ring_osc_clk, first_crystal_clk;
	wire second_crystal_clk, first_crystal_en, second_crystal_en, bias_gen_en;
	wire external_bias_sel, osc_supply_range, first_crystal_high_range;
	wire osc_fault_flag, nmi_req;
	int err_count = 0;
	int n_compared = 0;
	int cyc, r, s, f;
	logic [7:0] rv;
	logic [7:0] rx;
	logic [7:0] addrs [5] = '{8'h56, 8'h57, 8'h58, 8'h30, 8'h02};
	always #2 mclk = ~mclk;
	bcs_clock_ctrl #(.START_CYC(4)) bcs_clock_ctrl_i (.*);
	bcs_xtal_model #(.H1(5), .H2(3)) bcs_xtal_model_i (.*);
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, d);
		tick(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		tick(1);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	task automatic pulse(input logic por);
		tick(1);
		rst_b = 1'b0;
		por_rst_b = !por;
		tick(12);
		rst_b = 1'b1;
		por_rst_b = 1'b1;
	endtask
	function automatic logic sig(input int k);
		return k == 0 ? main_clk : k == 1 ? peripheral_clk :
			k == 2 ? aux_clk : ring_osc_clk;
	endfunction
	function automatic int per(input int h, d);
		return (2 * h) << d;
	endfunction
	// cycles spanned by n periods, -1 when the clock stands still
	task automatic period(input int k, n, output int c);
		int e, t;
		logic p;
		e = 0;
		p = sig(k);
		for (t = 0; t < 3000 && e <= n; t++) begin
			tick(1);
			if (sig(k) && !p) e++;
			if (sig(k) && !p && e == 1) c = t;
			if (sig(k) && !p && e == n + 1) c = t - c;
			p = sig(k);
		end
		if (e <= n) c = -1;
	endtask
	initial begin
		#400000;
		err_count++;
		complete_run;
	end
	initial begin
		void'($urandom(43));
		tick(12);
		rst_b = 1'b1;
		por_rst_b = 1'b1;
		rd(8'h56, rv);
		check("freq_reset", rv, 8'h60);
		rd(8'h57, rv);
		check("osc_reset", rv, 8'h04);
		repeat (6) begin
			rv = 8'($urandom);
			foreach (addrs[i]) begin
				wr(addrs[i], rv);
				rd(addrs[i], rx);
				check("readback", rx, i < 3 ? rv : 8'h00);
				if (i == 2) check("ext_bias", external_bias_sel, rv[0]);
			end
		end
		wr(8'h57, 8'hff);
		pulse(1'b0);
		rd(8'h57, rv);
		check("osc_clear", rv, 8'hf4);
		pulse(1'b1);
		rd(8'h57, rv);
		check("osc_por", rv, 8'h04);
		$display("test registers done");
		for (int d = 0; d < 4; d++) begin
			wr(8'h57, 8'(d << 4) | 8'h04);
			wr(8'h58, 8'hc8 | 8'(d << 4) | 8'(d << 1));
			tick(200);
			period(2, 1, cyc);
			check("aux_div", cyc, per(5, d));
			period(0, 1, cyc);
			check("main_div", cyc, per(5, d));
			period(1, 1, cyc);
			check("sub_div", cyc, per(3, d));
		end
		wr(8'h58, 8'h80);
		tick(50);
		period(0, 1, cyc);
		check("main_xt2", cyc, per(3, 0));
		wr(8'h58, 8'hc8);
		bias_gen_off = 1'b1;
		period(3, 1, cyc);
		check("ring_idle", cyc, -1);
		check("bias_off", bias_gen_en, 1'b0);
		wr(8'h58, 8'h40);
		check("bias_on", bias_gen_en, 1'b1);
		bias_gen_off = 1'b0;
		$display("test dividers done");
		for (int i = 0; i < 4; i++) begin
			r = $urandom % 8;
			s = i == 3 ? 7 : $urandom % 7;
			f = i == 0 ? 0 : $urandom % 32;
			wr(8'h57, 8'(r));
			wr(8'h56, 8'(s * 32 + f));
			tick(2600);
			period(3, 32, cyc);
			check("ring_frame", cyc, s == 7 ? 64 * (33 - r) :
				2 * (32 * (40 - r - s) - f));
		end
		$display("test ring done");
		cpu_clock_off = 1'b1;
		sub_clock_off = 1'b1;
		tick(200);
		period(0, 1, cyc);
		check("main_gated", cyc, -1);
		period(1, 1, cyc);
		check("sub_gated", cyc, -1);
		cpu_clock_off = 1'b0;
		sub_clock_off = 1'b0;
		lf_osc_off = 1'b1;
		tick(1);
		check("lf_stop", first_crystal_en, 1'b0);
		wr(8'h58, 8'hc0);
		check("lf_kept", first_crystal_en, 1'b1);
		wr(8'h57, 8'h84);
		check("xt2_stop", second_crystal_en, 1'b0);
		wr(8'h58, 8'h08);
		check("xt2_kept", second_crystal_en, 1'b1);
		$display("test oscillators done");
		crystal_fault_signal = 1'b1;
		tick(3);
		check("fault_flag", osc_fault_flag, 1'b1);
		check("nmi_masked", nmi_req, 1'b0);
		wr(8'h00, 8'h02);
		check("nmi_raised", nmi_req, 1'b1);
		nmi_accept = 1'b1;
		tick(1);
		nmi_accept = 1'b0;
		check("nmi_cleared", nmi_req, 1'b0);
		rd(8'h02, rv);
		check("flag_reg", rv, 8'h02);
		crystal_fault_signal = 1'b0;
		$display("test fault done");
		complete_run;
	end
endmodule // bcs_clock_ctrl_bench
`default_nettype wire

// File: testbench/bcs_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
// stopped crystal rests low; edges land on the falling mclk edge
module bcs_xtal_model #(
	parameter H1 = 5,
	parameter H2 = 3
) (
	input wire mclk,
	input wire first_crystal_en,
	input wire second_crystal_en,
	// start low so the first toggle never inverts an unknown
	output logic first_crystal_clk = 1'b0,
	output logic second_crystal_clk = 1'b0
);
	int c1 = 0;
	int c2 = 0;
	always @(negedge mclk) begin
		c1 <= (first_crystal_en === 1'b1 && c1 < H1 - 1) ? c1 + 1 : 0;
		c2 <= (second_crystal_en === 1'b1 && c2 < H2 - 1) ? c2 + 1 : 0;
		if (first_crystal_en !== 1'b1) first_crystal_clk <= 1'b0;
		else if (c1 == H1 - 1) first_crystal_clk <= !first_crystal_clk;
		if (second_crystal_en !== 1'b1) second_crystal_clk <= 1'b0;
		else if (c2 == H2 - 1) second_crystal_clk <= !second_crystal_clk;
	end
endmodule // bcs_xtal_model
`default_nettype wire

// File: verilog/bcs_clk_div.v
`timescale 1ns/1ps
`default_nettype none
// source select, divide by 1/2/4/8 and gate, changes taken only while low
module bcs_clk_div (
	input wire mclk,
	input wire rst_b,
	input wire [2:0] src_in,
	input wire [1:0] src_sel,
	input wire [1:0] div_sel,
	input wire gate_off,
	output wire clk_out
);
	reg [2:0] src_d_ff;
	reg [1:0] act_sel_ff;
	reg [1:0] act_div_ff;
	reg [2:0] cnt_ff;
	reg out_ff;
	reg nxt_out;
	wire cur;
	wire rise;
	wire change;
	assign cur = src_in[act_sel_ff];
	assign rise = cur && !src_d_ff[act_sel_ff];
	assign change = (src_sel != act_sel_ff) || (div_sel != act_div_ff);
	always @* begin
		case (act_div_ff)
		2'h0: nxt_out = cur;
		2'h1: nxt_out = rise ? ~cnt_ff[0] : cnt_ff[0];
		2'h2: nxt_out = cnt_ff[1] ^ (rise && cnt_ff[0]);
		default: nxt_out = cnt_ff[2] ^ (rise && (cnt_ff[1:0] == 2'h3));
		endcase
	end
	always @(posedge mclk) begin
		if (!rst_b) begin
			src_d_ff <= 3'h0;
			act_sel_ff <= 2'h0;
			act_div_ff <= 2'h0;
			cnt_ff <= 3'h0;
			out_ff <= 1'b0;
		end else begin
			src_d_ff <= src_in;
			// switch only with output and new source both low
			if (change && !out_ff && !src_in[src_sel]) begin
				act_sel_ff <= src_sel;
				act_div_ff <= div_sel;
				cnt_ff <= 3'h0;
			end else if (!(gate_off && !out_ff)) begin
				// gating stops the clock in its low phase only
				if (rise)
					cnt_ff <= cnt_ff + 3'h1;
				out_ff <= nxt_out;
			end
		end
	end
	assign clk_out = out_ff;
endmodule // bcs_clk_div
`default_nettype wire

// File: verilog/bcs_clock_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "bcs_clock_map.vh"
module bcs_clock_ctrl #(
	parameter HAS_SECOND = 1,
	parameter START_CYC = ((`BCS_START_NS * `BCS_MCLK_MHZ) + 999) / 1000
) (
	input wire mclk,
	input wire rst_b,
	input wire por_rst_b,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [7:0] reg_rdata,
	input wire cpu_clock_off,
	input wire sub_clock_off,
	input wire bias_gen_off,
	input wire lf_osc_off,
	input wire first_crystal_clk,
	input wire second_crystal_clk,
	input wire crystal_fault_signal,
	input wire nmi_accept,
	output wire main_clk,
	output wire peripheral_clk,
	output wire aux_clk,
	output wire ring_osc_clk,
	output wire first_crystal_en,
	output wire second_crystal_en,
	output wire bias_gen_en,
	output wire [2:0] bias_res_sel,
	output wire external_bias_sel,
	output wire osc_supply_range,
	output wire first_crystal_high_range,
	output wire osc_fault_flag,
	output wire nmi_req
);
	// pin synchronisers: crystal clocks and fault
	reg [2:0] sync1_ff;
	reg [2:0] sync2_ff;
	wire [2:0] pin_in;
	wire xt1_s;
	wire xt2_s;
	wire fault_s;
	assign pin_in = {crystal_fault_signal, second_crystal_clk,
		first_crystal_clk};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
			always @(posedge mclk) begin
				if (!rst_b) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= pin_in[gi];
					sync2_ff[gi] <= sync1_ff[gi];
				end
			end
		end
	endgenerate
	assign xt1_s = sync2_ff[0];
	assign xt2_s = sync2_ff[1];
	assign fault_s = sync2_ff[2];

	// registers
	reg [2:0] step_ff;
	reg [4:0] frac_ff;
	reg [2:0] rsel_ff;
	reg supply_ff;
	reg xt2_off_ff;
	reg hi_range_ff;
	reg [1:0] adiv_ff;
	reg [7:0] csd_ff;
	reg fault_en_ff;
	reg [7:0] rdata_ff;
	reg [7:0] nxt_rdata;

	function hit;
		input [7:0] a;
		input [7:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	wire wr_dco;
	wire wr_osc;
	wire wr_csd;
	wire wr_ie1;
	// byte-wide port only; no word access exists here
	assign wr_dco = reg_wr && hit(reg_addr, `BCS_ADDR_DCO);
	assign wr_osc = reg_wr && hit(reg_addr, `BCS_ADDR_OSC);
	assign wr_csd = reg_wr && hit(reg_addr, `BCS_ADDR_CSD);
	assign wr_ie1 = reg_wr && hit(reg_addr, `BCS_ADDR_IE1);

	// cleared by power-up clear
	always @(posedge mclk) begin
		if (!rst_b) begin
			step_ff <= `BCS_STEP_RST;
			frac_ff <= `BCS_FRAC_RST;
			rsel_ff <= `BCS_RSEL_RST;
			supply_ff <= `BCS_SUPPLY_RST;
			csd_ff <= `BCS_CSD_RST;
		end else begin
			if (wr_dco) begin
				step_ff <= reg_wdata[`BCS_STEP_MSB:`BCS_STEP_LSB];
				frac_ff <= reg_wdata[`BCS_FRAC_MSB:`BCS_FRAC_LSB];
			end
			if (wr_osc) begin
				rsel_ff <= reg_wdata[`BCS_RSEL_MSB:`BCS_RSEL_LSB];
				supply_ff <= reg_wdata[`BCS_SUPPLY_BIT];
			end
			if (wr_csd)
				csd_ff <= reg_wdata;
		end
	end

	// only power-on reset clears these, watchdog clear keeps them
	always @(posedge mclk) begin
		if (!por_rst_b) begin
			{xt2_off_ff, hi_range_ff, adiv_ff} <= `BCS_OSC_POR_RST;
		end else if (wr_osc) begin
			xt2_off_ff <= reg_wdata[`BCS_SECOND_CRYSTAL_OFF_BIT];
			hi_range_ff <= reg_wdata[`BCS_HIRANGE_BIT];
			adiv_ff <= reg_wdata[`BCS_ADIV_MSB:`BCS_ADIV_LSB];
		end
	end

	// accept clears the enable even against a same-cycle write
	always @(posedge mclk) begin
		if (!rst_b)
			fault_en_ff <= 1'b0;
		else if (nmi_accept)
			fault_en_ff <= 1'b0;
		else if (wr_ie1)
			fault_en_ff <= reg_wdata[`BCS_FAULT_BIT];
	end

	always @* begin
		nxt_rdata = 8'h00;
		if (hit(reg_addr, `BCS_ADDR_DCO))
			nxt_rdata = {step_ff, frac_ff};
		else if (hit(reg_addr, `BCS_ADDR_OSC))
			nxt_rdata = {xt2_off_ff, hi_range_ff, adiv_ff, supply_ff,
				rsel_ff};
		else if (hit(reg_addr, `BCS_ADDR_CSD))
			nxt_rdata = csd_ff;
		else if (hit(reg_addr, `BCS_ADDR_IE1))
			nxt_rdata[`BCS_FAULT_BIT] = fault_en_ff;
		else if (hit(reg_addr, `BCS_ADDR_IRQ_FLAG_REG_ONE))
			nxt_rdata[`BCS_FAULT_BIT] = fault_s;
	end
	always @(posedge mclk) begin
		if (!rst_b)
			rdata_ff <= 8'h00;
		else if (reg_rd)
			rdata_ff <= nxt_rdata;
	end
	assign reg_rdata = rdata_ff;

	// field decode
	wire [1:0] msel;
	wire [1:0] mdiv;
	wire psel;
	wire [1:0] pdiv;
	assign msel = csd_ff[`BCS_MSEL_MSB:`BCS_MSEL_LSB];
	assign mdiv = csd_ff[`BCS_MDIV_MSB:`BCS_MDIV_LSB];
	assign psel = csd_ff[`BCS_PSEL_BIT];
	assign pdiv = csd_ff[`BCS_PDIV_MSB:`BCS_PDIV_LSB];

	// a gated clock does not hold the ring oscillator alive; a crystal source stays enabled
	wire main_ring;
	wire per_ring;
	wire ring_need;
	wire main_xt1;
	wire main_xt2;
	wire per_xt1;
	wire per_xt2;
	assign main_ring = !cpu_clock_off && !msel[1];
	assign per_ring = !sub_clock_off && !psel;
	assign ring_need = main_ring || per_ring;
	assign main_xt2 = (msel == `BCS_MSEL_XT2);
	assign main_xt1 = (msel == `BCS_MSEL_XT1);
	assign per_xt2 = psel && (HAS_SECOND != 0);
	assign per_xt1 = psel && (HAS_SECOND == 0);

	assign bias_gen_en = !bias_gen_off || ring_need;
	assign first_crystal_en = !lf_osc_off || main_xt1 || per_xt1;
	assign second_crystal_en = (HAS_SECOND != 0) &&
		(!xt2_off_ff || main_xt2 || per_xt2);
	assign bias_res_sel = rsel_ff;
	assign external_bias_sel = csd_ff[`BCS_EXTB_BIT];
	assign osc_supply_range = supply_ff;
	assign first_crystal_high_range = hi_range_ff;
	assign osc_fault_flag = fault_s;
	assign nmi_req = fault_s && fault_en_ff;

	wire ring_clk;
	wire ring_ready;
	bcs_ring_osc #(
		.START_CYC(START_CYC)
	) u_ring (
		.mclk(mclk),
		.rst_b(rst_b),
		.run(ring_need),
		.bias_on(bias_gen_en),
		.step(step_ff),
		.frac(frac_ff),
		.rsel(rsel_ff),
		.ring_clk(ring_clk),
		.ready(ring_ready)
	);
	assign ring_osc_clk = ring_clk;

	// source vector indexed by BCS_SRC_* codes
	wire [2:0] srcs;
	wire [1:0] main_idx;
	wire [1:0] per_idx;
	wire per_x_sel;
	assign srcs = {xt1_s, xt2_s, ring_clk};
	assign main_idx = main_xt1 ? `BCS_SRC_XT1 :
		main_xt2 ? `BCS_SRC_XT2 : `BCS_SRC_RING;
	assign per_x_sel = (HAS_SECOND != 0);
	assign per_idx = !psel ? `BCS_SRC_RING :
		per_x_sel ? `BCS_SRC_XT2 : `BCS_SRC_XT1;

	bcs_clk_div u_main (
		.mclk(mclk),
		.rst_b(rst_b),
		.src_in(srcs),
		.src_sel(main_idx),
		.div_sel(mdiv),
		.gate_off(cpu_clock_off),
		.clk_out(main_clk)
	);
	bcs_clk_div u_per (
		.mclk(mclk),
		.rst_b(rst_b),
		.src_in(srcs),
		.src_sel(per_idx),
		.div_sel(pdiv),
		.gate_off(sub_clock_off),
		.clk_out(peripheral_clk)
	);
	bcs_clk_div u_aux (
		.mclk(mclk),
		.rst_b(rst_b),
		.src_in(srcs),
		.src_sel(`BCS_SRC_XT1),
		.div_sel(adiv_ff),
		.gate_off(1'b0),
		.clk_out(aux_clk)
	);
endmodule // bcs_clock_ctrl
`default_nettype wire

// File: verilog/bcs_clock_map.vh
`ifndef BCS_CLOCK_MAP_VH
`define BCS_CLOCK_MAP_VH
// byte register addresses
`define BCS_ADDR_IE1 8'h00
`define BCS_ADDR_IRQ_FLAG_REG_ONE 8'h02
`define BCS_ADDR_DCO 8'h56
`define BCS_ADDR_OSC 8'h57
`define BCS_ADDR_CSD 8'h58
// special function bits
`define BCS_FAULT_BIT 1
// frequency control fields
`define BCS_STEP_MSB 7
`define BCS_STEP_LSB 5
`define BCS_FRAC_MSB 4
`define BCS_FRAC_LSB 0
`define BCS_STEP_RST 3'h3
`define BCS_FRAC_RST 5'h00
`define BCS_STEP_MAX 3'h7
// oscillator control fields
`define BCS_SECOND_CRYSTAL_OFF_BIT 7
`define BCS_HIRANGE_BIT 6
`define BCS_ADIV_MSB 5
`define BCS_ADIV_LSB 4
`define BCS_SUPPLY_BIT 3
`define BCS_RSEL_MSB 2
`define BCS_RSEL_LSB 0
`define BCS_RSEL_RST 3'h4
`define BCS_SUPPLY_RST 1'b0
`define BCS_OSC_POR_RST 4'h0
// clock source / divider fields
`define BCS_MSEL_MSB 7
`define BCS_MSEL_LSB 6
`define BCS_MDIV_MSB 5
`define BCS_MDIV_LSB 4
`define BCS_PSEL_BIT 3
`define BCS_PDIV_MSB 2
`define BCS_PDIV_LSB 1
`define BCS_EXTB_BIT 0
`define BCS_CSD_RST 8'h00
// main source codes
`define BCS_MSEL_XT2 2'h2
`define BCS_MSEL_XT1 2'h3
// divider source indexes
`define BCS_SRC_RING 2'h0
`define BCS_SRC_XT2 2'h1
`define BCS_SRC_XT1 2'h2
// ring oscillator model
`define BCS_RING_HALF_BASE 8'd40
`define BCS_RING_FRAME 5'h1f
`define BCS_START_NS 1000
`define BCS_MCLK_MHZ 250
`endif

// File: verilog/bcs_ring_osc.v
`timescale 1ns/1ps
`default_nettype none
`include "bcs_clock_map.vh"
// digital model of the ring oscillator with its 32-cycle modulator
module bcs_ring_osc #(
	parameter START_CYC = ((`BCS_START_NS * `BCS_MCLK_MHZ) + 999) / 1000
) (
	input wire mclk,
	input wire rst_b,
	input wire run,
	input wire bias_on,
	input wire [2:0] step,
	input wire [4:0] frac,
	input wire [2:0] rsel,
	output wire ring_clk,
	output wire ready
);
	reg [9:0] start_cnt_ff;
	reg ready_ff;
	reg ring_ff;
	reg [7:0] half_cnt_ff;
	reg [4:0] frame_ff;
	wire use_up;
	wire [2:0] step_eff;
	wire [7:0] half_len;
	// output starts only after bias has settled
	always @(posedge mclk) begin
		if (!rst_b || !bias_on) begin
			start_cnt_ff <= 10'h000;
			ready_ff <= 1'b0;
		end else if (!ready_ff) begin
			if (start_cnt_ff == START_CYC[9:0] - 10'h001)
				ready_ff <= 1'b1;
			start_cnt_ff <= start_cnt_ff + 10'h001;
		end
	end
	// no higher step above seven
	assign use_up = (frame_ff < frac) && (step != `BCS_STEP_MAX);
	assign step_eff = use_up ? step + 3'h1 : step;
	assign half_len = `BCS_RING_HALF_BASE - {5'h00, rsel} -
		{5'h00, step_eff};
	always @(posedge mclk) begin
		if (!rst_b || !run || !ready_ff) begin
			ring_ff <= 1'b0;
			half_cnt_ff <= 8'h00;
			frame_ff <= 5'h00;
		end else if (half_cnt_ff >= half_len - 8'h01) begin
			half_cnt_ff <= 8'h00;
			ring_ff <= ~ring_ff;
			if (ring_ff)
				frame_ff <= frame_ff + 5'h01;
		end else begin
			half_cnt_ff <= half_cnt_ff + 8'h01;
		end
	end
	assign ring_clk = ring_ff;
	assign ready = ready_ff;
endmodule // bcs_ring_osc
`default_nettype wire
